/* qpte_accum.sv */
// Reserved-rate byte accumulator with minimum packet size padding
`timescale 1ns/100ps
module qpte_accum
   import qpte_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        pkt_valid,
   input  wire logic [15:0] pkt_bytes,
   input  wire logic [15:0] min_pkt,
   input  wire logic        clear,
   output logic [47:0]      byte_count
);

   logic [47:0] cnt_reg;
   logic [47:0] cnt_next;
   logic [15:0] eff;

   always_comb begin
      eff = (pkt_bytes < min_pkt) ? min_pkt : pkt_bytes;
      cnt_next = cnt_reg;
      if (clear) begin
         cnt_next = 48'h0000_0000_0000;
      end else if (pkt_valid) begin
         cnt_next = cnt_reg + {32'h0000_0000, eff};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 48'h0000_0000_0000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign byte_count = cnt_reg;

endmodule

/* qpte_countdown.sv */
// Loadable seconds countdown used by both QoS timeouts
`timescale 1ns/100ps
module qpte_countdown
   import qpte_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic        run,
   input  wire logic        tick,
   output logic             expire
);

   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        exp_reg;
   logic        exp_next;

   always_comb begin
      cnt_next = cnt_reg;
      exp_next = 1'b0;
      if (load) begin
         cnt_next = load_val;
      end else if (run && tick && cnt_reg != QPTE_TMO_ZERO) begin
         cnt_next = cnt_reg - 16'h0001;
         exp_next = (cnt_reg == 16'h0001);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 16'h0000;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign expire = exp_reg;

endmodule

/* qpte_dsc_sink.sv */
// Change-request consumer standing in for the modem side
`timescale 1ns/100ps
module qpte_dsc_sink
   import qpte_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  wire qpte_dsc_req_t dsc,
   input  wire logic [3:0]    stall,
   output logic               dsc_ready,
   output logic [7:0]         taken
);
   logic [3:0] wait_reg;
   // Only takes requests, never times flows out itself
   assign dsc_ready = dsc.valid && (wait_reg >= stall);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg <= 4'h0;
         taken <= 8'h00;
      end else if (dsc_ready) begin
         wait_reg <= 4'h0;
         taken <= taken + 8'h01;
      end else if (dsc.valid) begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

/* qpte_pkg.sv */
// Package with constants and carrier types for the QoS timeout enforcer
package qpte_pkg;

   // ==========================================
   // Parameter type codes and defaults
   // ==========================================
   localparam logic [7:0]  QPTE_TYPE_MIN_RATE   = 8'h0A;
   localparam logic [7:0]  QPTE_TYPE_MIN_PKT    = 8'h0B;
   localparam logic [7:0]  QPTE_TYPE_ACT_TMO    = 8'h0C;
   localparam logic [7:0]  QPTE_TYPE_ADM_TMO    = 8'h0D;
   localparam logic [7:0]  QPTE_TYPE_VENDOR     = 8'h2B;
   localparam logic [7:0]  QPTE_TYPE_VENDOR_ID  = 8'h08;
   localparam logic [31:0] QPTE_DEF_MIN_RATE    = 32'h0000_0000;
   localparam logic [15:0] QPTE_DEF_ACT_TMO     = 16'h0000;
   localparam logic [15:0] QPTE_DEF_ADM_TMO_S   = 16'h00C8;
   localparam logic [15:0] QPTE_DEF_MIN_PKT     = 16'h0040;

   // ==========================================
   // Timing
   // ==========================================
   localparam int          QPTE_CLK_MHZ         = 125;
   localparam int          QPTE_TICK_S          = 1;
   localparam int          QPTE_TICK_CYCLES     = QPTE_TICK_S * QPTE_CLK_MHZ * 1000000;
   localparam logic [15:0] QPTE_TMO_ZERO        = 16'h0000;

   // ==========================================
   // Carrier types
   // ==========================================
   typedef struct packed {
      logic        rate_present;
      logic [31:0] min_rate;
      logic        pkt_present;
      logic [15:0] min_pkt;
      logic        act_present;
      logic [15:0] act_tmo;
      logic        adm_present;
      logic [15:0] adm_tmo;
      logic        activate;
      logic        active_null;
      logic        adm_exceeds;
   } qpte_qos_msg_t;

   typedef struct packed {
      logic        valid;
      logic        set_active_null;
      logic        set_admitted_null;
      logic        adm_to_active;
      logic        release_admitted;
   } qpte_dsc_req_t;

endpackage

/* qpte_top.sv */
// QoS parameter interpreter and active/admitted timeout enforcer
`timescale 1ns/100ps
module qpte_top
   import qpte_pkg::*;
#(
   parameter int TICK_CYCLES = QPTE_TICK_CYCLES
)(
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  wire qpte_qos_msg_t msg,
   input  wire logic          msg_ack,
   input  wire logic [15:0]   prov_act_tmo,
   input  wire logic [15:0]   prov_adm_tmo,
   input  wire logic          pkt_valid,
   input  wire logic [15:0]   pkt_bytes,
   input  wire logic          req_valid,
   input  wire logic [31:0]   req_rate,
   input  wire logic          vend_valid,
   input  wire logic [7:0]    vend_first_type,
   input  wire logic          dsc_ready,
   output qpte_dsc_req_t      dsc,
   output logic [31:0]        grant_rate,
   output logic [31:0]        excess_rate,
   output logic               vend_accept,
   output logic               vend_discard,
   output logic [47:0]        byte_count,
   output logic [15:0]        act_tmo_used,
   output logic [15:0]        adm_tmo_used,
   output logic               active_on,
   output logic               adm_on
);

   // ==========================================
   // Reset synchroniser
   // ==========================================
   logic rst_s1_reg;
   logic rst_n;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_reg <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n      <= rst_s1_reg;
      end
   end

   // ==========================================
   // One-second tick divider
   // ==========================================
   logic [31:0] div_reg;
   logic [31:0] div_next;
   logic        tick;

   always_comb begin
      div_next = (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : div_reg + 32'h0000_0001;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= 32'h0000_0000;
      end else begin
         div_reg <= div_next;
      end
   end

   assign tick = (div_reg == 32'(TICK_CYCLES - 1));

   // ==========================================
   // Parameter interpretation on accepted messages
   // ==========================================
   logic        accept;
   logic [15:0] act_req;
   logic [15:0] adm_req;
   logic [15:0] adm_clip;
   logic [15:0] act_clip;

   assign accept = msg_ack;

   always_comb begin
      act_req  = msg.act_present ? msg.act_tmo : QPTE_DEF_ACT_TMO;
      adm_req  = msg.adm_present ? msg.adm_tmo : QPTE_DEF_ADM_TMO_S;
      adm_clip = (adm_req > prov_adm_tmo) ? prov_adm_tmo : adm_req;
      act_clip = (act_req > adm_clip) ? adm_clip : act_req;
      if (act_clip > prov_act_tmo) begin
         act_clip = prov_act_tmo;
      end
   end

   // ==========================================
   // Flow state registers
   // ==========================================
   logic [31:0] rate_reg;
   logic [31:0] rate_next;
   logic [15:0] mpkt_reg;
   logic [15:0] mpkt_next;
   logic [15:0] act_reg;
   logic [15:0] act_next;
   logic [15:0] adm_reg;
   logic [15:0] adm_next;
   logic        aon_reg;
   logic        aon_next;
   logic        don_reg;
   logic        don_next;
   logic        act_exp;
   logic        adm_exp;
   logic        pend_reg;
   logic        pend_next;
   logic        act_hit_reg;
   logic        act_hit_next;
   logic        adm_hit_reg;
   logic        adm_hit_next;
   logic        act_hold;
   logic        adm_hold;
   logic        act_fire;
   logic        adm_fire;
   qpte_dsc_req_t dsc_reg;
   qpte_dsc_req_t dsc_next;

   always_comb begin
      rate_next = rate_reg;
      mpkt_next = mpkt_reg;
      act_next  = act_reg;
      adm_next  = adm_reg;
      aon_next  = aon_reg;
      don_next  = don_reg;
      pend_next = pend_reg;
      dsc_next  = dsc_reg;
      act_fire  = 1'b0;
      adm_fire  = 1'b0;
      if (pend_reg && dsc_ready) begin
         pend_next = 1'b0;
         dsc_next  = '0;
      end
      if (accept) begin
         rate_next = msg.rate_present ? msg.min_rate : QPTE_DEF_MIN_RATE;
         mpkt_next = msg.pkt_present ? msg.min_pkt : QPTE_DEF_MIN_PKT;
         act_next  = act_clip;
         adm_next  = adm_clip;
         if (msg.active_null) begin
            aon_next = 1'b0;
         end else if (msg.activate) begin
            aon_next = (act_clip != QPTE_TMO_ZERO);
         end
         don_next = msg.adm_exceeds && (adm_clip != QPTE_TMO_ZERO);
      end else if (act_hold && aon_reg && !pend_next) begin
         act_fire  = 1'b1;
         aon_next  = 1'b0;
         don_next  = 1'b0;
         rate_next = QPTE_DEF_MIN_RATE;
         pend_next = 1'b1;
         dsc_next  = '{valid: 1'b1, set_active_null: 1'b1,
                       set_admitted_null: 1'b1, adm_to_active: 1'b0,
                       release_admitted: 1'b1};
      end else if (adm_hold && don_reg && !pend_next) begin
         adm_fire  = 1'b1;
         don_next  = 1'b0;
         pend_next = 1'b1;
         dsc_next  = '{valid: 1'b1, set_active_null: 1'b0,
                       set_admitted_null: 1'b0, adm_to_active: 1'b1,
                       release_admitted: 1'b1};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rate_reg <= QPTE_DEF_MIN_RATE;
         mpkt_reg <= QPTE_DEF_MIN_PKT;
         act_reg  <= QPTE_DEF_ACT_TMO;
         adm_reg  <= QPTE_DEF_ADM_TMO_S;
         aon_reg  <= 1'b0;
         don_reg  <= 1'b0;
         pend_reg <= 1'b0;
         dsc_reg  <= '0;
      end else begin
         rate_reg <= rate_next;
         mpkt_reg <= mpkt_next;
         act_reg  <= act_next;
         adm_reg  <= adm_next;
         aon_reg  <= aon_next;
         don_reg  <= don_next;
         pend_reg <= pend_next;
         dsc_reg  <= dsc_next;
      end
   end

   // ==========================================
   // Expiry latches
   // ==========================================
   // Expiry waits here while an earlier request is unanswered
   assign act_hold = act_hit_reg | act_exp;
   assign adm_hold = adm_hit_reg | adm_exp;

   always_comb begin
      act_hit_next = act_hold;
      adm_hit_next = adm_hold;
      if (pkt_valid || req_valid) begin
         act_hit_next = act_exp;   // Fresh traffic voids a held active expiry
      end
      if (accept || act_fire) begin
         act_hit_next = 1'b0;
         adm_hit_next = 1'b0;
      end else if (adm_fire) begin
         adm_hit_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         act_hit_reg <= 1'b0;
         adm_hit_reg <= 1'b0;
      end else begin
         act_hit_reg <= act_hit_next;
         adm_hit_reg <= adm_hit_next;
      end
   end

   // ==========================================
   // Timeout counters
   // ==========================================
   logic act_load;
   logic activity;

   assign activity = pkt_valid | req_valid;
   assign act_load = accept | (activity & aon_reg);

   qpte_countdown u_act_cnt (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .load     (act_load),
      .load_val (accept ? act_clip : act_reg),
      .run      (aon_reg),
      .tick     (tick),
      .expire   (act_exp)
   );

   qpte_countdown u_adm_cnt (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .load     (accept),
      .load_val (adm_clip),
      .run      (don_reg),
      .tick     (tick),
      .expire   (adm_exp)
   );

   // ==========================================
   // Byte accounting
   // ==========================================
   qpte_accum u_accum (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .pkt_valid  (pkt_valid),
      .pkt_bytes  (pkt_bytes),
      .min_pkt    (mpkt_reg),
      .clear      (1'b0),
      .byte_count (byte_count)
   );

   // ==========================================
   // Grant and vendor screening outputs
   // ==========================================
   logic [31:0] grant_reg;
   logic [31:0] grant_next;
   logic [31:0] exc_reg;
   logic [31:0] exc_next;
   logic        vacc_reg;
   logic        vacc_next;
   logic        vdis_reg;
   logic        vdis_next;

   always_comb begin
      grant_next = grant_reg;
      exc_next   = exc_reg;
      if (req_valid) begin
         grant_next = (req_rate < rate_reg) ? req_rate : rate_reg;
         exc_next   = (req_rate < rate_reg) ? rate_reg - req_rate : 32'h0000_0000;
      end
      vacc_next = vend_valid && (vend_first_type == QPTE_TYPE_VENDOR_ID);
      vdis_next = vend_valid && (vend_first_type != QPTE_TYPE_VENDOR_ID);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         grant_reg <= 32'h0000_0000;
         exc_reg   <= 32'h0000_0000;
         vacc_reg  <= 1'b0;
         vdis_reg  <= 1'b0;
      end else begin
         grant_reg <= grant_next;
         exc_reg   <= exc_next;
         vacc_reg  <= vacc_next;
         vdis_reg  <= vdis_next;
      end
   end

   assign grant_rate   = grant_reg;
   assign excess_rate  = exc_reg;
   assign vend_accept  = vacc_reg;
   assign vend_discard = vdis_reg;
   assign dsc          = dsc_reg;
   assign act_tmo_used = act_reg;
   assign adm_tmo_used = adm_reg;
   assign active_on    = aon_reg;
   assign adm_on       = don_reg;

endmodule

/* qpte_top_checker.sv */
// Port checks for the QoS timeout enforcer
`timescale 1ns/100ps
module qpte_top_checker
   import qpte_pkg::*;
#(
   parameter int TICK_CYCLES = 10
)(
   input wire logic          mclk,
   input wire logic          rst_b,
   input wire qpte_qos_msg_t msg,
   input wire logic          msg_ack,
   input wire logic [15:0]   prov_act_tmo,
   input wire logic [15:0]   prov_adm_tmo,
   input wire logic          pkt_valid,
   input wire logic [15:0]   pkt_bytes,
   input wire logic          req_valid,
   input wire logic [31:0]   req_rate,
   input wire logic          vend_valid,
   input wire logic [7:0]    vend_first_type,
   input wire logic          dsc_ready,
   input wire qpte_dsc_req_t dsc,
   input wire logic [31:0]   grant_rate,
   input wire logic [31:0]   excess_rate,
   input wire logic          vend_accept,
   input wire logic          vend_discard,
   input wire logic [47:0]   byte_count,
   input wire logic [15:0]   act_tmo_used,
   input wire logic [15:0]   adm_tmo_used,
   input wire logic          active_on,
   input wire logic          adm_on
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ==========================================
   // Change request shapes
   // ==========================================
   sequence s_act_req;
      dsc.valid && dsc.set_active_null && dsc.set_admitted_null && dsc.release_admitted;
   endsequence
   sequence s_adm_req;
      dsc.valid && dsc.adm_to_active && dsc.release_admitted && !dsc.set_active_null;
   endsequence
   // ==========================================
   // Assertions
   // ==========================================
   a_vend_ok: assert property (
      vend_valid && vend_first_type == QPTE_TYPE_VENDOR_ID |=> vend_accept && !vend_discard)
      else $error("vendor container not accepted");
   a_vend_drop: assert property (
      vend_valid && vend_first_type != QPTE_TYPE_VENDOR_ID |=> vend_discard && !vend_accept)
      else $error("vendor container not discarded");
   a_grant_cap: assert property (
      req_valid |=> grant_rate <= $past(req_rate) &&
         (excess_rate == 32'h0 || grant_rate == $past(req_rate)))
      else $error("grant or excess wrong");
   a_byte_pad: assert property (
      pkt_valid |=> byte_count - $past(byte_count) >= 48'($past(pkt_bytes)))
      else $error("byte count short");
   a_tmo_clip: assert property (
      msg_ack |=> adm_tmo_used <= $past(prov_adm_tmo) && act_tmo_used <= adm_tmo_used
         && act_tmo_used <= $past(prov_act_tmo))
      else $error("timeout not clipped");
   a_act_null: assert property (
      msg_ack && msg.active_null |=> !active_on)
      else $error("active timer kept running");
   a_adm_stop: assert property (
      msg_ack && !msg.adm_exceeds |=> !adm_on)
      else $error("admitted timer kept running");
   a_dsc_hold: assert property (
      dsc.valid && !dsc_ready |=> $stable(dsc))
      else $error("change request dropped");
   a_act_exp: assert property (
      $fell(active_on) && !$past(msg_ack) |-> ##[0:1] s_act_req)
      else $error("no null request on active expiry");
   a_adm_exp: assert property (
      $fell(adm_on) && !$fell(active_on) && !$past(msg_ack) |-> ##[0:1] s_adm_req)
      else $error("no release request on admitted expiry");
endmodule
bind qpte_top qpte_top_checker #(.TICK_CYCLES(TICK_CYCLES)) i_qpte_top_checker (
   .mclk, .rst_b, .msg, .msg_ack, .prov_act_tmo, .prov_adm_tmo, .pkt_valid, .pkt_bytes,
   .req_valid, .req_rate, .vend_valid, .vend_first_type, .dsc_ready, .dsc, .grant_rate,
   .excess_rate, .vend_accept, .vend_discard, .byte_count, .act_tmo_used, .adm_tmo_used,
   .active_on, .adm_on);

/* test_qpte_top.sv */
// Self-checking bench for the QoS timeout enforcer
`timescale 1ns/100ps
module test_qpte_top
   import qpte_pkg::*;
;
   logic          mclk = 1'b0;
   logic          rst_b = 1'b0;
   qpte_qos_msg_t msg = '0;
   logic          msg_ack = 1'b0;
   logic [15:0]   prov_act_tmo = 16'h0030;
   logic [15:0]   prov_adm_tmo = 16'h0100;
   logic          pkt_valid = 1'b0;
   logic [15:0]   pkt_bytes = 16'h0000;
   logic          req_valid = 1'b0;
   logic [31:0]   req_rate = 32'h0;
   logic          vend_valid = 1'b0;
   logic [7:0]    vend_first_type = 8'h00;
   logic [3:0]    stall = 4'h3;
   logic          dsc_ready;
   qpte_dsc_req_t dsc;
   logic [31:0]   grant_rate, excess_rate;
   logic          vend_accept, vend_discard, active_on, adm_on;
   logic [47:0]   byte_count;
   logic [15:0]   act_tmo_used, adm_tmo_used;
   logic [7:0]    taken;
   int            bad_count = 0;
   int            n_checks = 0;

   qpte_top #(.TICK_CYCLES(10)) i_qpte_top (
      .mclk, .rst_b, .msg, .msg_ack, .prov_act_tmo, .prov_adm_tmo, .pkt_valid, .pkt_bytes,
      .req_valid, .req_rate, .vend_valid, .vend_first_type, .dsc_ready, .dsc, .grant_rate,
      .excess_rate, .vend_accept, .vend_discard, .byte_count, .act_tmo_used,
      .adm_tmo_used, .active_on, .adm_on);
   qpte_dsc_sink i_qpte_dsc_sink (.mclk, .rst_b, .dsc, .stall, .dsc_ready, .taken);

   always #4 mclk = ~mclk;

   // ==========================================
   // Helpers
   // ==========================================
   task automatic ck(input string nm, input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   function automatic qpte_qos_msg_t mk(input logic [15:0] a, input logic [15:0] d,
      input logic [4:0] f);
      mk = '0;
      {mk.act_present, mk.adm_present, mk.activate, mk.active_null, mk.adm_exceeds} = f;
      mk.act_tmo = a;
      mk.adm_tmo = d;
   endfunction
   task automatic snd(input qpte_qos_msg_t m);
      msg = m;
      msg_ack = 1'b1;
      cyc(1);
      msg_ack = 1'b0;
      cyc(2);
   endtask
   task automatic rq(input logic [31:0] r);
      req_rate = r;
      req_valid = 1'b1;
      cyc(1);
      req_valid = 1'b0;
      cyc(1);
   endtask
   task automatic wdsc(output int n);
      n = 0;
      while (dsc.valid !== 1'b1) begin
         cyc(1);
         n++;
         if (n > 300) begin
            bad_count++;
            summarize();
         end
      end
   endtask

   // ==========================================
   // Scenarios
   // ==========================================
   task automatic t_dflt();
      ck("act_rst", act_tmo_used, 48'h0);
      ck("adm_rst", adm_tmo_used, 48'hC8);
      snd(mk(16'h0, 16'h0, 5'b00101));
      ck("act_tmo", act_tmo_used, 48'h0);
      ck("active_on", active_on, 48'h0);
      ck("adm_tmo", adm_tmo_used, 48'hC8);
      ck("adm_on", adm_on, 48'h1);
      rq(32'h3E8);
      ck("grant", grant_rate, 48'h0);
      $display("t_dflt done");
   endtask
   task automatic t_rate();
      qpte_qos_msg_t m;
      m = mk(16'h0, 16'h0, 5'b00000);
      m.rate_present = 1'b1;
      m.min_rate = 32'h3E8;
      snd(m);
      rq(32'h258);
      ck("grant", grant_rate, 48'h258);
      ck("excess", excess_rate, 48'h190);
      rq(32'h5DC);
      ck("grant", grant_rate, 48'h3E8);
      ck("excess", excess_rate, 48'h0);
      snd(mk(16'h0, 16'h0, 5'b00000));
      rq(32'h3E8);
      ck("grant_dflt", grant_rate, 48'h0);
      ck("excess_dflt", excess_rate, 48'h0);
      $display("t_rate done");
   endtask
   task automatic t_clip();
      snd(mk(16'h32, 16'h28, 5'b11001));
      ck("adm_tmo", adm_tmo_used, 48'h28);
      ck("act_tmo", act_tmo_used, 48'h28);
      snd(mk(16'h40, 16'h300, 5'b11001));
      ck("adm_tmo", adm_tmo_used, 48'h100);
      ck("act_tmo", act_tmo_used, 48'h30);
      $display("t_clip done");
   endtask
   task automatic t_pkt();
      qpte_qos_msg_t m;
      logic [47:0]   b;
      m = mk(16'h0, 16'h0, 5'b00000);
      m.pkt_present = 1'b1;
      m.min_pkt = 16'h64;
      snd(m);
      b = byte_count;
      pkt_valid = 1'b1;
      pkt_bytes = 16'h28;
      cyc(1);
      pkt_bytes = 16'hC8;
      cyc(1);
      pkt_valid = 1'b0;
      cyc(1);
      ck("bytes", byte_count, b + 48'h12C);
      $display("t_pkt done");
   endtask
   task automatic t_vend();
      logic [7:0] tl [4] = '{8'h08, 8'h2B, 8'h00, 8'hFF};
      foreach (tl[i]) begin
         vend_first_type = tl[i];
         vend_valid = 1'b1;
         cyc(1);
         ck("accept", vend_accept, 48'(tl[i] == QPTE_TYPE_VENDOR_ID));
         ck("discard", vend_discard, 48'(tl[i] != QPTE_TYPE_VENDOR_ID));
      end
      vend_valid = 1'b0;
      cyc(1);
      $display("t_vend done");
   endtask
   task automatic t_act();
      int         n;
      logic [7:0] t0;
      t0 = taken;
      snd(mk(16'h3, 16'h3, 5'b11100));
      ck("active_on", active_on, 48'h1);
      cyc(15);
      rq(32'h0);
      wdsc(n);
      ck("act_wait", 48'(n >= 18 && n <= 45), 48'h1);
      ck("null_act", dsc.set_active_null, 48'h1);
      ck("null_adm", dsc.set_admitted_null, 48'h1);
      cyc(6);
      ck("taken", taken, 48'(t0 + 8'h01));
      ck("active_on", active_on, 48'h0);
      $display("t_act done");
   endtask
   task automatic t_adm();
      int n;
      stall = 4'h0;
      snd(mk(16'h0, 16'h2, 5'b01001));
      ck("adm_on", adm_on, 48'h1);
      wdsc(n);
      ck("copy", dsc.adm_to_active, 48'h1);
      ck("release", dsc.release_admitted, 48'h1);
      ck("keep_act", dsc.set_active_null, 48'h0);
      cyc(2);
      ck("adm_on", adm_on, 48'h0);
      snd(mk(16'h10, 16'h10, 5'b11100));
      ck("active_on", active_on, 48'h1);
      snd(mk(16'h0, 16'h0, 5'b00010));
      ck("active_on", active_on, 48'h0);
      $display("t_adm done");
   endtask

   initial begin
      cyc(20);
      rst_b = 1'b1;
      cyc(3);
      t_dflt();
      t_rate();
      t_clip();
      t_pkt();
      t_vend();
      t_act();
      t_adm();
      summarize();
   end
endmodule
